// ===== hw/gxr_regs.svh
`ifndef GXR_REGS_SVH
`define GXR_REGS_SVH
// ==========================================================
// Register indices; the byte address is four times the index.
`define GXR_IDX_GIG_STAT2 5'h11
`define GXR_IDX_BYPASS 5'h12
`define GXR_IDX_RXERR_CNT 5'h13
`define GXR_IDX_FCAR_CNT 5'h14
`define GXR_IDX_LINK_DROP_CNT 5'h15
`define GXR_IDX_TEN_CTRL 5'h16
// ==========================================================
// Reset values and writable masks.
`define GXR_BYPASS_RESET 16'h0088
`define GXR_BYPASS_WMASK 16'hfefe
`define GXR_TEN_RESET 16'h3200
`define GXR_TEN_WMASK 16'hfe06
// ==========================================================
// Field positions.
`define GXR_BIT_GIG_LOCKED 15
`define GXR_BIT_GIG_LOCK_ERR 14
`define GXR_BIT_GIG_DISC 13
`define GXR_BIT_GIG_LINK 12
`define GXR_BIT_GIG_RXERR 11
`define GXR_BIT_GIG_TXERR 10
`define GXR_BIT_GIG_SSD 9
`define GXR_BIT_GIG_ESD 8
`define GXR_BIT_GIG_CEXT 7
`define GXR_BIT_LEGACY_DET 6
`define GXR_BIT_XOVER_ERR 5
`define GXR_BIT_TEN_EOF 8
`define GXR_BIT_TEN_DISC 7
`define GXR_BIT_TEN_LINK 6
`define GXR_CNT_MAX 8'hff
`endif

// ===== hw/gxr_pkg.sv
package gxr_pkg;
  // ==========================================================
  // Event strobes and live levels coming from the PHY core.
  typedef struct packed {
    logic gig_locked;
    logic gig_link;
    logic tx_link;
    logic gig_lock_err;
    logic gig_disc;
    logic gig_rx_err;
    logic gig_tx_err;
    logic gig_ssd_err;
    logic gig_esd_err;
    logic gig_cext_err;
    logic legacy_partner;
    logic xover_err;
    logic rx_err;
    logic false_carrier;
    logic link_drop;
    logic ten_eof_err;
    logic ten_disc;
    logic ten_link;
    logic receiving;
    logic transmitting;
    logic full_duplex_flag;
  } gxr_core_in_type;
  // ==========================================================
  // Controls handed back to the PHY core.
  typedef struct packed {
    logic tx_output_off;
    logic bypass_4b5b;
    logic bypass_scrambler;
    logic bypass_descrambler;
    logic bypass_pcs_rx;
    logic bypass_pcs_tx;
    logic bypass_link_fail_timer;
    logic no_auto_mdix_forced;
    logic legacy_detect_off;
    logic mdix_correct_off;
    logic polarity_correct_off;
    logic honor_advertised;
    logic pulse_shape_off;
    logic next_page_auto_off;
    logic ten_link_sm_off;
    logic ten_jabber_off;
    logic ten_echo_off;
    logic ten_sqe_off;
    logic [1:0] squelch_sel;
    logic sticky_reset_en;
  } gxr_ctrl_out_type;
  typedef struct packed {
    logic [6:0] gig_sticky;
    logic legacy_det;
    logic xover_det;
    logic [15:0] bypass;
    logic [15:0] ten_ctrl;
    logic [1:0] ten_sticky;
    logic [7:0] rxerr_cnt;
    logic [7:0] fcar_cnt;
    logic [7:0] drop_cnt;
    logic [31:0] rdata;
    logic rvalid;
    logic carrier_sense;
  } gxr_state_type;
endpackage

// ===== hw/gxr_ext_regs.sv
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "gxr_regs.svh"
// Summary of operation
// - Gigabit error flags held until read, cleared.
// - Lock and link bits live, read-only.
// - Crossover and legacy-partner flags read-only, reset 0.
// - Control bit stops legacy-partner detection.
// - Control bit stops transmitter driving media.
// - Six datapath bypass bits, reset 0.
// - Auto crossover off in forced mode, reset 1.
// - Crossover and polarity correction disable bits.
// - Parallel detect honors advertised abilities; reset 1.
// - Control bit disables transmit pulse shaping.
// - Control bit suppresses automatic next pages.
// - Shared receive error counter, saturating, read-clear.
// - Shared false-carrier counter, saturating, read-clear.
// - Link drop counter, saturating, read-clear.
// - Link-integrity and jabber disable bits, reset 0.
// - Echo and quality test disables, reset 1.
// - Squelch threshold select field, reset nominal.
// - Carrier-sense formula chosen by two-bit field.
module gxr_ext_regs (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire gxr_pkg::gxr_core_in_type core_in,
  output gxr_pkg::gxr_ctrl_out_type ctrl_out,
  output logic carrier_sense_out
);
  import gxr_pkg::*;

  gxr_state_type st_ff;
  gxr_state_type nxt_st;
  logic [5:0] idx;
  logic rd_go;
  logic wr_go;
  logic lo_en;
  logic hi_en;
  logic [15:0] wmask;
  logic [15:0] rd_word;
  logic [6:0] gig_ev;
  logic tx_fdx;

  // ==========================================================
  // Bus decode. A read is captured into the data register in its
  // first cycle and completes in the second, so the data already
  // stand at the edge where waitrequest is seen low; writes complete
  // at once.
  assign idx = avs_address[7:2];
  assign rd_go = avs_read && st_ff.rvalid;
  assign wr_go = avs_write;
  assign avs_waitrequest = avs_read && !st_ff.rvalid;
  assign avs_readdata = st_ff.rdata;
  assign lo_en = avs_byteenable[0];
  assign hi_en = avs_byteenable[1];
  assign wmask = {{8{hi_en}}, {8{lo_en}}};
  assign carrier_sense_out = st_ff.carrier_sense;

  // Event vector in the same order as bits 14,13,11..7.
  assign gig_ev = {core_in.gig_lock_err, core_in.gig_disc,
                   core_in.gig_rx_err, core_in.gig_tx_err,
                   core_in.gig_ssd_err, core_in.gig_esd_err,
                   core_in.gig_cext_err};

  // ==========================================================
  // Read mux; reserved positions stay zero.
  always_comb begin
    rd_word = 16'h0000;
    unique case (idx)
      6'(`GXR_IDX_GIG_STAT2): begin
        rd_word[`GXR_BIT_GIG_LOCKED] = core_in.gig_locked;
        rd_word[`GXR_BIT_GIG_LINK] = core_in.gig_link;
        rd_word[14:13] = st_ff.gig_sticky[6:5];
        rd_word[11:7] = st_ff.gig_sticky[4:0];
        rd_word[`GXR_BIT_LEGACY_DET] = st_ff.legacy_det;
        rd_word[`GXR_BIT_XOVER_ERR] = st_ff.xover_det;
      end
      6'(`GXR_IDX_BYPASS): rd_word = st_ff.bypass;
      6'(`GXR_IDX_RXERR_CNT): rd_word[7:0] = st_ff.rxerr_cnt;
      6'(`GXR_IDX_FCAR_CNT): rd_word[7:0] = st_ff.fcar_cnt;
      6'(`GXR_IDX_LINK_DROP_CNT): rd_word[7:0] = st_ff.drop_cnt;
      6'(`GXR_IDX_TEN_CTRL): begin
        rd_word = st_ff.ten_ctrl;
        rd_word[`GXR_BIT_TEN_EOF] = st_ff.ten_sticky[1];
        rd_word[`GXR_BIT_TEN_DISC] = st_ff.ten_sticky[0];
        rd_word[`GXR_BIT_TEN_LINK] = core_in.ten_link;
      end
      default: rd_word = 16'h0000;
    endcase
  end

  // ==========================================================
  // Next-state logic. A read clears only what it actually returned,
  // and events arriving after the capture or in the clearing cycle
  // survive, so nothing is lost between sampling and clearing.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rvalid = avs_read && !st_ff.rvalid;
    if (avs_read && !st_ff.rvalid) begin
      nxt_st.rdata = {16'h0000, rd_word};
    end
    // Gigabit sticky flags.
    if (rd_go && idx == 6'(`GXR_IDX_GIG_STAT2)) begin
      nxt_st.gig_sticky = st_ff.gig_sticky &
        ~{st_ff.rdata[14:13], st_ff.rdata[11:7]};
    end
    nxt_st.gig_sticky = nxt_st.gig_sticky | gig_ev;
    // Legacy detection stops while its disable bit is set.
    nxt_st.legacy_det = core_in.legacy_partner &&
                        !st_ff.bypass[6];
    nxt_st.xover_det = core_in.xover_err;
    // 10BASE-T sticky flags.
    if (rd_go && idx == 6'(`GXR_IDX_TEN_CTRL)) begin
      nxt_st.ten_sticky = st_ff.ten_sticky &
        ~{st_ff.rdata[8], st_ff.rdata[7]};
    end
    nxt_st.ten_sticky = nxt_st.ten_sticky |
                        {core_in.ten_eof_err, core_in.ten_disc};
    // Counters: clear on read, then count, stopping at the top.
    if (rd_go && idx == 6'(`GXR_IDX_RXERR_CNT)) begin
      nxt_st.rxerr_cnt = st_ff.rxerr_cnt - st_ff.rdata[7:0];
    end
    if (core_in.rx_err && (core_in.gig_link || core_in.tx_link) &&
        nxt_st.rxerr_cnt != `GXR_CNT_MAX) begin
      nxt_st.rxerr_cnt = nxt_st.rxerr_cnt + 8'h01;
    end
    if (rd_go && idx == 6'(`GXR_IDX_FCAR_CNT)) begin
      nxt_st.fcar_cnt = st_ff.fcar_cnt - st_ff.rdata[7:0];
    end
    if (core_in.false_carrier &&
        (core_in.gig_link || core_in.tx_link) &&
        nxt_st.fcar_cnt != `GXR_CNT_MAX) begin
      nxt_st.fcar_cnt = nxt_st.fcar_cnt + 8'h01;
    end
    if (rd_go && idx == 6'(`GXR_IDX_LINK_DROP_CNT)) begin
      nxt_st.drop_cnt = st_ff.drop_cnt - st_ff.rdata[7:0];
    end
    if (core_in.link_drop && nxt_st.drop_cnt != `GXR_CNT_MAX) begin
      nxt_st.drop_cnt = nxt_st.drop_cnt + 8'h01;
    end
    // Control writes honour byte lanes and writable masks.
    if (wr_go && idx == 6'(`GXR_IDX_BYPASS)) begin
      nxt_st.bypass = (st_ff.bypass & ~(wmask & `GXR_BYPASS_WMASK)) |
        (avs_writedata[15:0] & wmask & `GXR_BYPASS_WMASK);
    end
    if (wr_go && idx == 6'(`GXR_IDX_TEN_CTRL)) begin
      nxt_st.ten_ctrl = (st_ff.ten_ctrl & ~(wmask & `GXR_TEN_WMASK)) |
        (avs_writedata[15:0] & wmask & `GXR_TEN_WMASK);
    end
    // Carrier sense from the selected formula.
    tx_fdx = core_in.transmitting && !core_in.full_duplex_flag;
    unique case (st_ff.ten_ctrl[2:1])
      2'h0: nxt_st.carrier_sense = core_in.receiving || tx_fdx;
      2'h1: nxt_st.carrier_sense = (core_in.receiving ||
              core_in.transmitting) && !core_in.full_duplex_flag;
      2'h2: nxt_st.carrier_sense = core_in.receiving;
      2'h3: nxt_st.carrier_sense = core_in.receiving &&
              !core_in.full_duplex_flag;
    endcase
  end

  // ==========================================================
  // State register.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
      st_ff.bypass <= `GXR_BYPASS_RESET;
      st_ff.ten_ctrl <= `GXR_TEN_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // Control outputs straight from the registered fields.
  assign ctrl_out.tx_output_off = st_ff.bypass[15];
  assign ctrl_out.bypass_4b5b = st_ff.bypass[14];
  assign ctrl_out.bypass_scrambler = st_ff.bypass[13];
  assign ctrl_out.bypass_descrambler = st_ff.bypass[12];
  assign ctrl_out.bypass_pcs_rx = st_ff.bypass[11];
  assign ctrl_out.bypass_pcs_tx = st_ff.bypass[10];
  assign ctrl_out.bypass_link_fail_timer = st_ff.bypass[9];
  assign ctrl_out.no_auto_mdix_forced = st_ff.bypass[7];
  assign ctrl_out.legacy_detect_off = st_ff.bypass[6];
  assign ctrl_out.mdix_correct_off = st_ff.bypass[5];
  assign ctrl_out.polarity_correct_off = st_ff.bypass[4];
  assign ctrl_out.honor_advertised = st_ff.bypass[3];
  assign ctrl_out.pulse_shape_off = st_ff.bypass[2];
  assign ctrl_out.next_page_auto_off = st_ff.bypass[1];
  assign ctrl_out.ten_link_sm_off = st_ff.ten_ctrl[15];
  assign ctrl_out.ten_jabber_off = st_ff.ten_ctrl[14];
  assign ctrl_out.ten_echo_off = st_ff.ten_ctrl[13];
  assign ctrl_out.ten_sqe_off = st_ff.ten_ctrl[12];
  assign ctrl_out.squelch_sel = st_ff.ten_ctrl[11:10];
  assign ctrl_out.sticky_reset_en = st_ff.ten_ctrl[9];
endmodule
`default_nettype wire

// ===== bench/gxr_core_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// PHY core stand-in: steady levels plus one-cycle event pulses.
module gxr_core_model
  import gxr_pkg::*;
(
  input wire logic mclk,
  output gxr_pkg::gxr_core_in_type core_in
);
  gxr_core_in_type lvl_ff = '0;
  gxr_core_in_type pls_ff = '0;
  // Pulses ride on the levels so events and link states combine freely.
  assign core_in = lvl_ff | pls_ff;
  task automatic set_lvl(input gxr_core_in_type v);
    @(posedge mclk);
    lvl_ff <= v;
  endtask
  // Events last exactly one cycle, as the core produces them.
  task automatic pulse(input gxr_core_in_type v);
    @(posedge mclk);
    pls_ff <= v;
    @(posedge mclk);
    pls_ff <= '0;
  endtask
endmodule
`default_nettype wire

// ===== bench/gxr_ext_regs_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Bus timing and control output properties.
module gxr_ext_regs_checker
  import gxr_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire gxr_pkg::gxr_core_in_type core_in,
  input wire gxr_pkg::gxr_ctrl_out_type ctrl_out,
  input wire logic carrier_sense_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Writes never stall; reads stall for exactly one cycle.
  write_nowait_a: assert property (avs_write |-> !avs_waitrequest)
    else $error("write stalled");
  read_wait_a: assert property (avs_read && avs_waitrequest |=>
    !avs_waitrequest) else $error("read stalled too long");
  upper_zero_a: assert property (avs_read && !avs_waitrequest |->
    avs_readdata[31:16] == 16'h0) else $error("upper half not zero");
  tx_off_a: assert property (avs_write && avs_address == 8'h48 &&
    avs_byteenable[1] |=> ctrl_out.tx_output_off == $past(avs_writedata[15]))
    else $error("transmit disable not taken");
  advert_a: assert property (avs_write && avs_address == 8'h48 &&
    avs_byteenable[0] |=> ctrl_out.honor_advertised == $past(avs_writedata[3]))
    else $error("advertised ability bit not taken");
  squelch_a: assert property (avs_write && avs_address == 8'h58 &&
    avs_byteenable[1] |=> ctrl_out.squelch_sel == $past(avs_writedata[11:10]))
    else $error("squelch select not taken");
  // Every carrier mode agrees on these three corner cases.
  cs_rx_a: assert property (core_in.receiving &&
    !core_in.full_duplex_flag |=> carrier_sense_out) else $error("no carrier");
  cs_idle_a: assert property (!core_in.receiving &&
    !core_in.transmitting |=> !carrier_sense_out) else $error("idle carrier");
  cs_fdx_a: assert property (core_in.full_duplex_flag &&
    !core_in.receiving |=> !carrier_sense_out) else $error("duplex carrier");
  cover property (avs_read && !avs_waitrequest && avs_readdata[7:0] == 8'hff);
  cover property (avs_write && avs_address == 8'h48);
  cover property (carrier_sense_out && core_in.transmitting);
endmodule
bind gxr_ext_regs gxr_ext_regs_checker i_chk (.mclk(mclk), .arst_n(arst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .core_in(core_in), .ctrl_out(ctrl_out),
  .carrier_sense_out(carrier_sense_out));
`default_nettype wire

// ===== bench/gxr_ext_regs_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Self-checking bench for the extended register bank.
module gxr_ext_regs_tb_top;
  import gxr_pkg::*;
  logic mclk = 1'b0, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0] avs_address = 8'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h3;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, carrier_sense_out;
  gxr_core_in_type core_in, lv, ev;
  gxr_ctrl_out_type ctrl_out;
  logic [15:0] exp_q[$];
  logic [15:0] d;
  int err_count = 0, check_count = 0, seed = 32'h39fa485a;
  gxr_ext_regs i_dut (.mclk(mclk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .core_in(core_in), .ctrl_out(ctrl_out),
    .carrier_sense_out(carrier_sense_out));
  gxr_core_model i_core (.mclk(mclk), .core_in(core_in));
  initial begin
    forever #4 mclk = ~mclk;
  end
  task automatic wrap_up;
    if (err_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Holds the request until waitrequest is seen low at an edge.
  task automatic xfer(input logic rw, input logic [7:0] a, input logic [15:0] v);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= {16'h0, v};
    if (rw) avs_read <= 1'b1;
    else avs_write <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      err_count++;
      wrap_up();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    xfer(1'b1, a, 16'h0);
  endtask
  // Read data are compared at the edge that completes each read.
  always @(posedge mclk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
      chk(avs_readdata, {16'h0, exp_q.pop_front()});
    end
  end
  function automatic logic cs_exp(input int m, input logic r, t, f);
    case (m)
      0: return r | (t & ~f);
      1: return (r | t) & ~f;
      2: return r;
      default: return r & ~f;
    endcase
  endfunction
  initial begin
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    rd(8'h48, 16'h0088);
    rd(8'h58, 16'h3200);
    rd(8'h44, 16'h0000);
    xfer(1'b0, 8'h5c, 16'hffff);
    rd(8'h5c, 16'h0000);
    d = 16'($random(seed));
    xfer(1'b0, 8'h48, d);
    chk({31'h0, ctrl_out.tx_output_off}, {31'h0, d[15]});
    chk({31'h0, ctrl_out.legacy_detect_off}, {31'h0, d[6]});
    rd(8'h48, d & 16'hfefe);
    lv = '0;
    lv.gig_locked = 1'b1;
    lv.gig_link = 1'b1;
    i_core.set_lvl(lv);
    ev = '0;
    ev.gig_rx_err = 1'b1;
    ev.gig_lock_err = 1'b1;
    i_core.pulse(ev);
    i_core.pulse(ev);
    rd(8'h44, 16'hd800);
    rd(8'h44, 16'h9000);
    i_core.set_lvl('0);
    ev = '0;
    ev.rx_err = 1'b1;
    ev.false_carrier = 1'b1;
    ev.link_drop = 1'b1;
    repeat (2) i_core.pulse(ev);
    rd(8'h4c, 16'h0000);
    rd(8'h50, 16'h0000);
    rd(8'h54, 16'h0002);
    i_core.set_lvl(lv);
    repeat (257) i_core.pulse(ev);
    rd(8'h4c, 16'h00ff);
    rd(8'h50, 16'h00ff);
    rd(8'h54, 16'h00ff);
    rd(8'h4c, 16'h0000);
    for (int m = 0; m < 4; m++) begin
      xfer(1'b0, 8'h58, 16'h3200 | 16'(m << 1));
      for (int k = 0; k < 8; k++) begin
        lv = '0;
        {lv.receiving, lv.transmitting, lv.full_duplex_flag} = 3'(k);
        i_core.set_lvl(lv);
        repeat (2) @(posedge mclk);
        chk({31'h0, carrier_sense_out}, {31'h0, cs_exp(m, k[2], k[1], k[0])});
      end
    end
    repeat (3) @(posedge mclk);
    wrap_up();
  end
endmodule
`default_nettype wire
